// ### design/clock_gate_pkg.sv
// package of register offsets, field layouts and mode codes for peripheral clock gating
// assumes a 12-bit offset bus inside the system control window and one 25 MHz clock
package clock_gate_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // addressing
    localparam logic [31:0] SYSCTL_BASE = 32'h400F_E000;  // window base, decoded upstream
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam logic [11:0] OFF_RUN_PORT = 12'h108;
    localparam logic [11:0] OFF_SLEEP_PORT = 12'h118;
    localparam logic [11:0] OFF_DEEP_PORT = 12'h128;
    localparam logic [11:0] OFF_DEEP_PERIPH = 12'h124;
    localparam logic [11:0] OFF_RUN_PERIPH = 12'h300;
    localparam logic [11:0] OFF_SLEEP_PERIPH = 12'h304;
    localparam logic [11:0] OFF_CLK_CFG = 12'h308;
    localparam logic [11:0] OFF_IRQ_STATUS = 12'h310;
    localparam logic [11:0] OFF_IRQ_MASK = 12'h314;

    ////////////////////////////////////////////////////////////////////////////
    // field layouts and reset values
    localparam int N_PORT = 8;
    localparam int N_PERIPH = 9;
    localparam int N_UNIT = N_PORT + N_PERIPH;
    localparam logic [31:0] PORT_RW_MASK = 32'h0000_00FF;
    localparam logic [31:0] PERIPH_RW_MASK = 32'h0007_1133;
    localparam logic [31:0] GATE_RESET = 32'h0000_0000;
    localparam int AUTO_GATE_BIT = 0;
    localparam int IRQ_PORT_FAULT_BIT = 0;
    localparam int IRQ_PERIPH_FAULT_BIT = 1;
    localparam int IRQ_W = 2;
    // periph register bit of each periph unit, unit 0 upward:
    // uart 0,1, sync serial 0,1, quad decoder, i2c, timer 0,1,2
    localparam int PERIPH_BIT [N_PERIPH] = '{0, 1, 4, 5, 8, 12, 16, 17, 18};

    ////////////////////////////////////////////////////////////////////////////
    // power modes
    typedef enum logic [1:0] {
        MODE_RUN = 2'b00,
        MODE_SLEEP = 2'b01,
        MODE_DEEP = 2'b10
    } power_mode_t;

endpackage

// ### design/gate_cell.sv
// glitch-free clock gate cell with a matching unit hold signal
// assumes en comes from flops on clk; the latch is open while clk is low
`timescale 1ns/1ps
module gate_cell (
    input wire logic clk,
    input wire logic en,
    output logic gclk,
    output logic unit_run
);
    logic en_latched;

    // latch the enable while clk is low so gclk never sees a short pulse
    always_latch begin
        if (!clk) begin
            en_latched <= en;
        end
    end

    assign gclk = clk & en_latched;
    assign unit_run = en;  // unit held disabled whenever its clock is off
endmodule

// ### design/mode_select.sv
// picks the gating word in force for the current power mode
// assumes the three words and the mode come from flops on the same clock
`timescale 1ns/1ps
module mode_select import clock_gate_pkg::*; #(
    parameter int W = 8
) (
    input wire logic auto_gate,
    input wire power_mode_t mode,
    input wire logic [W-1:0] run_word,
    input wire logic [W-1:0] sleep_word,
    input wire logic [W-1:0] deep_word,
    output logic [W-1:0] active_word
);
    // without auto gating the run word rules every mode
    always_comb begin
        active_word = run_word;
        if (auto_gate) begin
            case (mode)
                MODE_SLEEP: active_word = sleep_word;
                MODE_DEEP: active_word = deep_word;
                default: active_word = run_word;
            endcase
        end
    end
endmodule

// ### design/periph_clock_gating.sv
// peripheral clock gating control: gating registers, mode selection, gated clocks, bus faults
// assumes a one-cycle register port on clk, mode levels and unit access strobes from logic on clk
// Operation
// [R1] set bit clocks its unit, clear bit holds it
// [R2] access to ungated unit answers bus fault
// [R3] every gating bit resets to zero
// [R4] software enables units before using them
// [R5] run, sleep, deep-sleep words apply per mode
// [R6] sleep words only apply with auto select
// [R7] run port register at offset 0x108
// [R8] bits 7..0 gate ports h down to a
// [R9] reserved bits read zero, ignore writes
// [R10] software preserves reserved bits on update
// [R11] bits 18..16 gate timers 2..0
// [R12] bit 12 gates the i2c unit
// [R13] bit 8 gates the quadrature decoder
// [R14] bits 5..4 gate sync serial 1..0
// [R15] bits 1..0 gate uart 1..0
// [R16] unused positions behave as reserved
// [R17] deep-sleep periph register at offset 0x124
// [R18] without auto select run words always apply
`timescale 1ns/1ps
module periph_clock_gating import clock_gate_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic sleep_now,
    input wire logic deep_sleep_now,
    input wire logic [N_PORT-1:0] port_access,
    input wire logic [N_PERIPH-1:0] periph_access,
    output logic bus_fault,
    output logic [N_PORT-1:0] port_gclk,
    output logic [N_PORT-1:0] port_run,
    output logic [N_PERIPH-1:0] periph_gclk,
    output logic [N_PERIPH-1:0] periph_run,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////
    // register state
    logic [DATA_W-1:0] run_port_gate_reg;
    logic [DATA_W-1:0] sleep_port_gate_reg;
    logic [DATA_W-1:0] deepsleep_port_gate_reg;
    logic [DATA_W-1:0] run_periph_gate_reg;
    logic [DATA_W-1:0] sleep_periph_gate_reg;
    logic [DATA_W-1:0] deepsleep_periph_gate_reg;
    logic [DATA_W-1:0] run_clock_config;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;

    // a write keeps only the implemented bits; the rest stay zero for ever
    function automatic logic [DATA_W-1:0] masked(input logic [DATA_W-1:0] d, input logic [DATA_W-1:0] m);
        return d & m;
    endfunction

    // address decode, one hit wire per register
    logic hit_run_port;
    logic hit_sleep_port;
    logic hit_deep_port;
    logic hit_run_periph;
    logic hit_sleep_periph;
    logic hit_deep_periph;
    logic hit_clk_cfg;
    logic hit_irq_status;
    logic hit_irq_mask;
    assign hit_run_port = (reg_addr == OFF_RUN_PORT);  // R7
    assign hit_sleep_port = (reg_addr == OFF_SLEEP_PORT);
    assign hit_deep_port = (reg_addr == OFF_DEEP_PORT);
    assign hit_run_periph = (reg_addr == OFF_RUN_PERIPH);
    assign hit_sleep_periph = (reg_addr == OFF_SLEEP_PERIPH);
    assign hit_deep_periph = (reg_addr == OFF_DEEP_PERIPH);  // R17
    assign hit_clk_cfg = (reg_addr == OFF_CLK_CFG);
    assign hit_irq_status = (reg_addr == OFF_IRQ_STATUS);
    assign hit_irq_mask = (reg_addr == OFF_IRQ_MASK);

    ////////////////////////////////////////////////////////////////////////////
    // next values of the writable registers
    logic [DATA_W-1:0] next_run_port;
    logic [DATA_W-1:0] next_sleep_port;
    logic [DATA_W-1:0] next_deep_port;
    logic [DATA_W-1:0] next_run_periph;
    logic [DATA_W-1:0] next_sleep_periph;
    logic [DATA_W-1:0] next_deep_periph;
    logic [DATA_W-1:0] next_clk_cfg;
    logic [IRQ_W-1:0] next_irq_mask;
    assign next_run_port = (reg_write && hit_run_port) ?
        masked(reg_wdata, PORT_RW_MASK) : run_port_gate_reg;  // R8 R9
    assign next_sleep_port = (reg_write && hit_sleep_port) ?
        masked(reg_wdata, PORT_RW_MASK) : sleep_port_gate_reg;
    assign next_deep_port = (reg_write && hit_deep_port) ?
        masked(reg_wdata, PORT_RW_MASK) : deepsleep_port_gate_reg;
    assign next_run_periph = (reg_write && hit_run_periph) ?
        masked(reg_wdata, PERIPH_RW_MASK) : run_periph_gate_reg;
    assign next_sleep_periph = (reg_write && hit_sleep_periph) ?
        masked(reg_wdata, PERIPH_RW_MASK) : sleep_periph_gate_reg;
    assign next_deep_periph = (reg_write && hit_deep_periph) ?
        masked(reg_wdata, PERIPH_RW_MASK) : deepsleep_periph_gate_reg;  // R9 R16
    assign next_clk_cfg = (reg_write && hit_clk_cfg) ?
        (reg_wdata & (32'h0000_0001 << AUTO_GATE_BIT)) : run_clock_config;
    assign next_irq_mask = (reg_write && hit_irq_mask) ? reg_wdata[IRQ_W-1:0] : irq_mask;

    // gating registers, all cleared so every unit starts unclocked
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_port_gate_reg <= GATE_RESET;  // R3
            sleep_port_gate_reg <= GATE_RESET;
            deepsleep_port_gate_reg <= GATE_RESET;
            run_periph_gate_reg <= GATE_RESET;
            sleep_periph_gate_reg <= GATE_RESET;
            deepsleep_periph_gate_reg <= GATE_RESET;  // R3
        end else begin
            run_port_gate_reg <= next_run_port;
            sleep_port_gate_reg <= next_sleep_port;
            deepsleep_port_gate_reg <= next_deep_port;
            run_periph_gate_reg <= next_run_periph;
            sleep_periph_gate_reg <= next_sleep_periph;
            deepsleep_periph_gate_reg <= next_deep_periph;
        end
    end

    // configuration and interrupt mask
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_clock_config <= GATE_RESET;
            irq_mask <= '0;
        end else begin
            run_clock_config <= next_clk_cfg;
            irq_mask <= next_irq_mask;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // power mode; deep sleep wins when both levels are high
    power_mode_t mode;
    logic auto_gate;
    assign mode = deep_sleep_now ? MODE_DEEP : (sleep_now ? MODE_SLEEP : MODE_RUN);
    assign auto_gate = run_clock_config[AUTO_GATE_BIT];

    // gather the scattered periph bits into a dense unit vector
    logic [N_PERIPH-1:0] run_periph_vec;
    logic [N_PERIPH-1:0] sleep_periph_vec;
    logic [N_PERIPH-1:0] deep_periph_vec;
    genvar g;
    generate
        for (g = 0; g < N_PERIPH; g++) begin : g_gather
            assign run_periph_vec[g] = run_periph_gate_reg[PERIPH_BIT[g]];  // R11 R12 R13 R14 R15
            assign sleep_periph_vec[g] = sleep_periph_gate_reg[PERIPH_BIT[g]];
            assign deep_periph_vec[g] = deepsleep_periph_gate_reg[PERIPH_BIT[g]];
        end
    endgenerate

    // words in force for the present mode
    logic [N_PORT-1:0] port_en_mux;
    logic [N_PERIPH-1:0] periph_en_mux;
    mode_select #(.W(N_PORT)) u_port_sel (
        .auto_gate(auto_gate),  // R6 R18
        .mode(mode),  // R5
        .run_word(run_port_gate_reg[N_PORT-1:0]),
        .sleep_word(sleep_port_gate_reg[N_PORT-1:0]),
        .deep_word(deepsleep_port_gate_reg[N_PORT-1:0]),
        .active_word(port_en_mux)
    );
    mode_select #(.W(N_PERIPH)) u_periph_sel (
        .auto_gate(auto_gate),  // R6 R18
        .mode(mode),  // R5
        .run_word(run_periph_vec),
        .sleep_word(sleep_periph_vec),
        .deep_word(deep_periph_vec),
        .active_word(periph_en_mux)
    );

    // register the selected enables so the clock gates see a clean flop output
    logic [N_PORT-1:0] port_en;
    logic [N_PERIPH-1:0] periph_en;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port_en <= '0;
            periph_en <= '0;
        end else begin
            port_en <= port_en_mux;
            periph_en <= periph_en_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // one clock gate per unit
    generate
        for (g = 0; g < N_PORT; g++) begin : g_port_gate
            gate_cell u_gate (
                .clk(clk),
                .en(port_en[g]),  // R1
                .gclk(port_gclk[g]),
                .unit_run(port_run[g])
            );
        end
        for (g = 0; g < N_PERIPH; g++) begin : g_periph_gate
            gate_cell u_gate (
                .clk(clk),
                .en(periph_en[g]),  // R1
                .gclk(periph_gclk[g]),
                .unit_run(periph_run[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // bus fault: answered the cycle after an access to an unclocked unit
    logic port_fault_now;
    logic periph_fault_now;
    assign port_fault_now = |(port_access & ~port_en);  // R2
    assign periph_fault_now = |(periph_access & ~periph_en);  // R2
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_fault <= 1'b0;
        end else begin
            bus_fault <= port_fault_now | periph_fault_now;
        end
    end

    // sticky fault status, cleared by reading it; a new fault beats the clear
    logic [IRQ_W-1:0] fault_set;
    logic [IRQ_W-1:0] next_irq_status;
    assign fault_set[IRQ_PORT_FAULT_BIT] = port_fault_now;
    assign fault_set[IRQ_PERIPH_FAULT_BIT] = periph_fault_now;
    assign next_irq_status = ((reg_read && hit_irq_status) ? '0 : irq_status) | fault_set;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_status <= '0;
        end else begin
            irq_status <= next_irq_status;
        end
    end
    assign irq = |(irq_status & irq_mask);

    ////////////////////////////////////////////////////////////////////////////
    // read mux; unmapped offsets read zero and never stall the master
    logic [DATA_W-1:0] read_word;
    assign read_word =
        hit_run_port ? run_port_gate_reg :  // R9
        hit_sleep_port ? sleep_port_gate_reg :
        hit_deep_port ? deepsleep_port_gate_reg :
        hit_run_periph ? run_periph_gate_reg :
        hit_sleep_periph ? sleep_periph_gate_reg :
        hit_deep_periph ? deepsleep_periph_gate_reg :
        hit_clk_cfg ? run_clock_config :
        hit_irq_status ? {{(DATA_W-IRQ_W){1'b0}}, irq_status} :
        hit_irq_mask ? {{(DATA_W-IRQ_W){1'b0}}, irq_mask} :
        32'h0000_0000;

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= reg_read ? read_word : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks on the gating logic
    gate_follows_run_a: assert property (@(posedge clk) disable iff (!rst_n) // R1
        !auto_gate |=> port_run == $past(run_port_gate_reg[N_PORT-1:0]))
        else $error("port enable does not follow run word");

    fault_on_off_a: assert property (@(posedge clk) disable iff (!rst_n) // R2
        (port_access != 0 && (port_access & ~port_run) != 0) |=> bus_fault)
        else $error("access to unclocked port gave no fault");

    no_fault_on_a: assert property (@(posedge clk) disable iff (!rst_n) // R2
        ((port_access & ~port_run) == 0 && (periph_access & ~periph_run) == 0) |=> !bus_fault)
        else $error("fault raised for clocked unit");

    reserved_port_a: assert property (@(posedge clk) disable iff (!rst_n) // R9
        (run_port_gate_reg & ~PORT_RW_MASK) == 0 && (deepsleep_periph_gate_reg & ~PERIPH_RW_MASK) == 0)
        else $error("reserved bit became set");

    port_write_a: assert property (@(posedge clk) disable iff (!rst_n) // R8
        (reg_write && reg_addr == OFF_RUN_PORT) |=> run_port_gate_reg[7:0] == $past(reg_wdata[7:0]))
        else $error("run port word missed a write");

    deep_timer_a: assert property (@(posedge clk) disable iff (!rst_n) // R11
        (reg_write && reg_addr == OFF_DEEP_PERIPH) |=> deepsleep_periph_gate_reg[18:16] == $past(reg_wdata[18:16]))
        else $error("timer gate bits missed a write");

    deep_select_a: assert property (@(posedge clk) disable iff (!rst_n) // R5
        (auto_gate && deep_sleep_now) |=> periph_run[5] == $past(deepsleep_periph_gate_reg[12]))
        else $error("deep word not applied in deep sleep");

    sleep_select_a: assert property (@(posedge clk) disable iff (!rst_n) // R6
        (auto_gate && sleep_now && !deep_sleep_now) |=> port_run == $past(sleep_port_gate_reg[7:0]))
        else $error("sleep word not applied in sleep");

    read_once_a: assert property (@(posedge clk) disable iff (!rst_n) // R7
        (reg_read && reg_addr == OFF_RUN_PORT) |=> reg_rdata == $past(run_port_gate_reg) ##1 (reg_rdata == 0 || $past(reg_read)))
        else $error("run port read data wrong or held");

    reset_clear_a: assert property (@(posedge clk) $rose(rst_n) |-> run_port_gate_reg == 0 && port_run == 0) // R3
        else $error("gating not clear after reset");

    deep_uart_a: assert property (@(posedge clk) disable iff (!rst_n) // R15
        (reg_write && reg_addr == OFF_DEEP_PERIPH) |=> deepsleep_periph_gate_reg[1:0] == $past(reg_wdata[1:0]))
        else $error("uart gate bits missed a write");

    deep_serial_a: assert property (@(posedge clk) disable iff (!rst_n) // R14
        (reg_write && reg_addr == OFF_DEEP_PERIPH) |=> deepsleep_periph_gate_reg[5:4] == $past(reg_wdata[5:4]))
        else $error("sync serial gate bits missed a write");

    deep_quad_a: assert property (@(posedge clk) disable iff (!rst_n) // R13
        (reg_write && reg_addr == OFF_DEEP_PERIPH) |=> deepsleep_periph_gate_reg[8] == $past(reg_wdata[8]))
        else $error("quad decoder gate bit missed a write");

    deep_i2c_a: assert property (@(posedge clk) disable iff (!rst_n) // R12
        (reg_write && reg_addr == OFF_DEEP_PERIPH) |=> deepsleep_periph_gate_reg[12] == $past(reg_wdata[12]))
        else $error("i2c gate bit missed a write");

    port_rsvd_read_a: assert property (@(posedge clk) disable iff (!rst_n) // R9
        (reg_read && reg_addr == OFF_RUN_PORT) |=> (reg_rdata & ~PORT_RW_MASK) == 0)
        else $error("reserved run port bit read non-zero");

    periph_rsvd_read_a: assert property (@(posedge clk) disable iff (!rst_n) // R9 R16
        (reg_read && reg_addr == OFF_DEEP_PERIPH) |=> (reg_rdata & ~PERIPH_RW_MASK) == 0)
        else $error("reserved periph bit read non-zero");

    periph_fault_a: assert property (@(posedge clk) disable iff (!rst_n) // R2
        (periph_access & ~periph_run) != 0 |=> bus_fault)
        else $error("access to unclocked unit gave no fault");

    periph_follow_run_a: assert property (@(posedge clk) disable iff (!rst_n) // R18
        !auto_gate |=> periph_run == $past(run_periph_vec))
        else $error("unit enable does not follow run word");

    periph_sleep_a: assert property (@(posedge clk) disable iff (!rst_n) // R6
        (auto_gate && sleep_now && !deep_sleep_now) |=> periph_run == $past(sleep_periph_vec))
        else $error("sleep unit word not applied");

    port_deep_a: assert property (@(posedge clk) disable iff (!rst_n) // R5
        (auto_gate && deep_sleep_now) |=> port_run == $past(deepsleep_port_gate_reg[N_PORT-1:0]))
        else $error("deep port word not applied");

    fault_wins_a: assert property (@(posedge clk) disable iff (!rst_n) // R2
        (reg_read && hit_irq_status && port_fault_now) |=> irq_status[IRQ_PORT_FAULT_BIT])
        else $error("read clear lost a new fault");

endmodule

// ### verif/gated_units_model.sv
// far-side model of the gated units: each unit notes whether its gated clock ticked
// assumes the gated clocks come straight from the gating block; clear is a short pulse
`timescale 1ns/1ps
module gated_units_model import clock_gate_pkg::*; (
    input wire logic [N_PORT-1:0] port_gclk,
    input wire logic [N_PERIPH-1:0] periph_gclk,
    input wire logic clear,
    output logic [N_UNIT-1:0] seen
);
    ////////////////////////////////////////////////////////////////////////////
    // a unit only runs on its own clock, so a held-off unit must never see an edge
    wire logic [N_UNIT-1:0] unit_clk = {periph_gclk, port_gclk};
    for (genvar i = 0; i < N_UNIT; i++) begin : unit_g
        logic hit;
        // one flag per unit, no shared driver between units
        always @(posedge unit_clk[i] or posedge clear) begin
            if (clear) begin
                hit <= 1'b0;
            end else begin
                hit <= 1'b1;
            end
        end
        assign seen[i] = hit;
    end
endmodule

// ### verif/peripheral_clock_gating_test.sv
// self-checking bench for the gating block: registers, unit clocks, faults, modes, interrupt
// assumes one 25 MHz clock and the one-cycle register port of the design
`timescale 1ns/1ps
module peripheral_clock_gating_test import clock_gate_pkg::*; ();
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic sleep_now = 1'b0;
    logic deep_sleep_now = 1'b0;
    logic [N_PORT-1:0] port_access = '0;
    logic [N_PERIPH-1:0] periph_access = '0;
    logic bus_fault, irq, clear_seen = 1'b0;
    logic [N_PORT-1:0] port_gclk, port_run;
    logic [N_PERIPH-1:0] periph_gclk, periph_run;
    logic [N_UNIT-1:0] seen;
    int fail_count = 0;
    int n_compared = 0;
    integer seed = 32'h8dd4;
    logic [31:0] v, w, s, d, sp, dp;
    logic [7:0] p;
    logic [8:0] q;
    logic [1:0] st = 2'b00;

    ////////////////////////////////////////////////////////////////////////////
    // 40 ns clock, design and far-side model
    always #20 clk = ~clk;
    periph_clock_gating dut_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .sleep_now(sleep_now),
        .deep_sleep_now(deep_sleep_now), .port_access(port_access), .periph_access(periph_access),
        .bus_fault(bus_fault), .port_gclk(port_gclk), .port_run(port_run), .periph_gclk(periph_gclk),
        .periph_run(periph_run), .irq(irq));
    gated_units_model units_u (.port_gclk(port_gclk), .periph_gclk(periph_gclk), .clear(clear_seen),
        .seen(seen));

    ////////////////////////////////////////////////////////////////////////////
    // unit enables of a periph word, timer 2 down to uart 0
    function automatic logic [8:0] units_of(input logic [31:0] x);
        units_of = {x[18], x[17], x[16], x[12], x[8], x[5], x[4], x[1], x[0]};
    endfunction

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    // strobes are one cycle; the next task waits for a fresh edge before raising one
    task automatic wr(input logic [11:0] a, input logic [31:0] x);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= x;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        check(what, exp, reg_rdata);
    endtask

    // one access cycle; the fault answer stands only in the following cycle
    task automatic acc(input logic [7:0] pa, input logic [8:0] qa, input logic exp);
        @(posedge clk);
        port_access <= pa;
        periph_access <= qa;
        @(posedge clk);
        port_access <= '0;
        periph_access <= '0;
        #1;
        check("bus_fault", {31'h0, exp}, {31'h0, bus_fault});
    endtask

    // mode levels reach the enables one edge later
    task automatic mode(input logic sl, input logic dsl, input logic [7:0] ep, input logic [8:0] eq);
        @(posedge clk);
        sleep_now <= sl;
        deep_sleep_now <= dsl;
        tick();
        check("port_run", {24'h0, ep}, {24'h0, port_run});
        check("periph_run", {23'h0, eq}, {23'h0, periph_run});
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // watchdog sized well beyond the few hundred cycles the sequence needs
    initial begin
        #(40 * 20000);
        fail_count++;
        final_report();
    end

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd(OFF_RUN_PORT, 32'h0, "run_port_gate_reg");
        rd(OFF_DEEP_PERIPH, 32'h0, "deepsleep_periph_gate_reg");
        check("units_off", 32'h0, {14'h0, port_run, periph_run, irq});
        // all-ones corner first, then random words: only the unit bits hold
        for (int i = 0; i < 6; i++) begin
            v = (i == 0) ? 32'hFFFF_FFFF : $random(seed);
            wr(OFF_RUN_PORT, v);
            rd(OFF_RUN_PORT, v & 32'h0000_00FF, "run_port_gate_reg");
            wr(OFF_DEEP_PERIPH, v);
            rd(OFF_DEEP_PERIPH, v & 32'h0007_1133, "deepsleep_periph_gate_reg");
        end
        rd(12'h10C, 32'h0, "unmapped");
        // read-modify-write: reserved bits go back as read, only the i2c bit flips
        rd(OFF_DEEP_PERIPH, v & PERIPH_RW_MASK, "deepsleep_periph_gate_reg");
        w = reg_rdata & ~PERIPH_RW_MASK;
        wr(OFF_DEEP_PERIPH, w | ((v ^ 32'h0000_1000) & PERIPH_RW_MASK));
        rd(OFF_DEEP_PERIPH, (v ^ 32'h0000_1000) & PERIPH_RW_MASK, "deepsleep_periph_gate_reg");
        // walk one unit at a time through the run words
        for (int i = 0; i < 9; i++) begin
            wr(OFF_RUN_PORT, 32'h1 << i);
            wr(OFF_RUN_PERIPH, 32'h1 << (i == 0 ? 0 : i == 1 ? 1 : i < 4 ? i + 2 : i == 4 ? 8 : i == 5 ? 12 : i + 10));
            tick();
            check("port_run", i < 8 ? 32'h1 << i : 32'h0, {24'h0, port_run});
            check("periph_run", 32'h1 << i, {23'h0, periph_run});
        end
        // random enables: gated clocks tick only where enabled, others fault
        for (int i = 0; i < 6; i++) begin
            v = $random(seed);
            w = $random(seed);
            wr(OFF_RUN_PORT, v);
            wr(OFF_RUN_PERIPH, w);
            tick();
            clear_seen = 1'b1;
            #1 clear_seen = 1'b0;
            repeat (3) tick();
            check("gated_clocks", {15'h0, units_of(w), v[7:0]}, {15'h0, seen});
            p = (i == 0) ? v[7:0] : 8'($random(seed));
            q = (i == 0) ? units_of(w) : 9'($random(seed));
            st = st | {|(q & ~units_of(w)), |(p & ~v[7:0])};
            acc(p, q, |(p & ~v[7:0]) | |(q & ~units_of(w)));
        end
        rd(OFF_IRQ_STATUS, {30'h0, st}, "irq_status");
        // interrupt raised, read-cleared, then masked
        wr(OFF_IRQ_MASK, 32'h3);
        wr(OFF_RUN_PORT, 32'h0F);
        wr(OFF_RUN_PERIPH, 32'h0);
        tick();
        acc(8'h10, 9'h0, 1'b1);
        check("irq", 32'h1, {31'h0, irq});
        rd(OFF_IRQ_STATUS, 32'h1, "irq_status");
        check("irq", 32'h0, {31'h0, irq});
        acc(8'h0, 9'h020, 1'b1);
        wr(OFF_IRQ_MASK, 32'h1);
        tick();
        check("irq", 32'h0, {31'h0, irq});
        rd(OFF_IRQ_STATUS, 32'h2, "irq_status");
        acc(8'h01, 9'h0, 1'b0);
        // a fault in the very cycle of the clearing read must survive it
        fork
            acc(8'h20, 9'h0, 1'b1);
            rd(OFF_IRQ_STATUS, 32'h0, "irq_status");
        join
        rd(OFF_IRQ_STATUS, 32'h1, "irq_status");
        // mode words: without auto select the run words stay in force
        {v, w, s, d, sp, dp} = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
        wr(OFF_RUN_PORT, v);
        wr(OFF_RUN_PERIPH, w);
        wr(OFF_SLEEP_PORT, s);
        wr(OFF_DEEP_PORT, d);
        wr(OFF_SLEEP_PERIPH, sp);
        wr(OFF_DEEP_PERIPH, dp);
        wr(OFF_CLK_CFG, 32'h0);
        mode(1'b1, 1'b0, v[7:0], units_of(w));
        mode(1'b0, 1'b1, v[7:0], units_of(w));
        wr(OFF_CLK_CFG, 32'h1);
        mode(1'b0, 1'b1, d[7:0], units_of(dp));
        mode(1'b1, 1'b1, d[7:0], units_of(dp));
        mode(1'b1, 1'b0, s[7:0], units_of(sp));
        mode(1'b0, 1'b0, v[7:0], units_of(w));
        final_report();
    end
endmodule
